// ---- include/adpil_pkg.sv ----
// shared constants for the auxiliary digital port with inhibit and error log
// assumes a 200 MHz core clock and a 32-bit Avalon-MM register bus
package adpil_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_PIN_CFG  = 8'h00; // functions, polarity, inhibit mode
    localparam logic [7:0] ADR_GPIO     = 8'h04; // out levels (w), in levels (r)
    localparam logic [7:0] ADR_CTRL     = 8'h08; // control bits
    localparam logic [7:0] ADR_STATUS   = 8'h0C; // block state
    localparam logic [7:0] ADR_CODE_IN  = 8'h10; // code entry
    localparam logic [7:0] ADR_CODE_NEW = 8'h14; // replace code while unlocked
    localparam logic [7:0] ADR_LOCK     = 8'h18; // any write relocks
    localparam logic [7:0] ADR_LOG_CTRL = 8'h1C; // bit 8 clear all, [5:0] entry number
    localparam logic [7:0] ADR_LOG_DATA = 8'h20; // {chan, code} of selected entry
    localparam logic [7:0] ADR_LOG_TIME = 8'h24; // timestamp of selected entry
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int FN_W        = 3;  // function field width per pin
    localparam int POL_LSB     = 9;  // polarity bits [11:9], 1 = negative
    localparam int INH_LSB     = 12; // inhibit mode [13:12]
    localparam int CT_FAULT_EN = 0;  // fault output enable
    localparam int CT_STEP_END = 1;  // trigger out at step end, else begin
    localparam int CT_LIST_SRC = 2;  // list trigger source is the port
    localparam int CT_LOG_SRC  = 3;  // logger trigger source is the port
    localparam int CT_KEY_OPT  = 4;  // key-lock option
    localparam int CT_REENABLE = 5;  // w1: release latched inhibit
    localparam int CT_UNLOCK   = 6;  // w1: unlock front panel keys
    localparam int CT_FLT_CLR  = 7;  // w1: clear fault event
    localparam int CT_W        = 5;  // stored control bits
    localparam int LOG_CLR_BIT = 8;
    // ----------------------------------------------------------------
    // encodings and reset values
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        FN_NONE = 3'h0, FN_GP_IN = 3'h1, FN_GP_OUT = 3'h2,
        FN_TRG_IN = 3'h3, FN_TRG_OUT = 3'h4, FN_FLT_INH = 3'h5
    } adpil_fn_e;
    typedef enum logic [1:0] {
        INH_OFF = 2'h0, INH_LATCH = 2'h1, INH_LIVE = 2'h2
    } adpil_inh_e;
    localparam logic [15:0] ERR_OVP   = 16'h0001;
    localparam logic [15:0] ERR_OCP   = 16'h0002;
    localparam logic [15:0] ERR_OTP   = 16'h0004;
    localparam logic [15:0] ERR_SENSE = 16'h0008;
    localparam logic [15:0] ERR_FAULT = ERR_OVP | ERR_OCP | ERR_OTP;
    localparam logic [31:0] CODE_RST  = 32'h77416699; // eight digits, one per nibble
    localparam logic [5:0]  LOG_DEPTH = 6'h32;        // 50 entries
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ     = 200000000;
    localparam longint KEY_HOLD_S = 3;
    localparam longint KEY_HOLD_CYC = KEY_HOLD_S * CLK_HZ;
endpackage

// ---- core/adpil_sync.sv ----
// two-stage synchroniser for asynchronous pin levels
// assumes one clock; the first stage feeds only the second
`timescale 1ns/10ps
module adpil_sync #(
    parameter int W = 4
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_reset,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    // ----------------------------------------------------------------
    // per-bit flop pair
    // ----------------------------------------------------------------
    logic [W-1:0] meta_ff; // first stage, read only by second stage
    for (genvar g = 0; g < W; g++) begin : g_bit
        always_ff @(posedge i_ref_clk) begin
            if (i_reset) begin
                meta_ff[g] <= 1'b0;
                o_sync[g]  <= 1'b0;
            end else begin
                meta_ff[g] <= i_async[g];
                o_sync[g]  <= meta_ff[g];
            end
        end
    end
endmodule

// ---- core/adpil_top.sv ----
// auxiliary digital port: pin functions, inhibit, fault out, error log,
// security code gate and front panel key lock
// assumes pins and key button are asynchronous; all else on i_ref_clk
// Functional notes
// - three pins, five functions, default none
// - per-pin polarity, default positive
// - general output drives, general input samples
// - trigger input advances list when selected
// - trigger input toggles logging when selected
// - trigger out pulses at step begin/end
// - protection error raises fault, drives fault pin
// - fault disables outputs by minimum setpoint
// - inhibit input only on pin three
// - inhibit mode off ignores input
// - latched inhibit holds outputs disabled
// - live inhibit follows input level
// - log holds fifty, then stops until cleared
// - entry one is always most recent
// - entry holds one-hot code, time, channel
// - clear all empties log
// - security locked until correct code; changeable
// - lock command relocks security
// - key-lock hold three seconds locks keys
// - key-lock option defaults disabled
`timescale 1ns/10ps
module adpil_top
    import adpil_pkg::*;
#(
    parameter logic [29:0] P_KEY_HOLD_CYC = 30'(KEY_HOLD_CYC) // shorten in simulation
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic [7:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    output logic      [31:0] o_readdata,
    output logic             o_waitrequest,
    input  wire logic [2:0]  i_pin_in,
    output logic      [2:0]  o_pin_out,
    output logic      [2:0]  o_pin_oe_n,
    input  wire logic        i_list_running,
    input  wire logic        i_step_begin,
    input  wire logic        i_step_end,
    output logic             o_list_step_trig,
    output logic             o_log_toggle,
    output logic             o_out_disable,
    input  wire logic        i_err_valid,
    input  wire logic [15:0] i_err_code,
    input  wire logic [1:0]  i_err_chan,
    input  wire logic [31:0] i_timestamp,
    input  wire logic        i_key_lock_btn,
    output logic             o_keys_locked,
    output logic             o_secure_unlocked
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic             wait_r;      // avalon wait state
        logic [31:0]      rdata;       // read data
        adpil_fn_e [2:0]  fn;          // pin functions
        logic [2:0]       pol_neg;     // 1 = negative polarity
        adpil_inh_e       inh_mode;    // inhibit mode
        logic [2:0]       gp_out;      // logic value for general outputs
        logic [CT_W-1:0]  ctrl;        // stored control bits
        logic [2:0]       in_prev;     // previous asserted input levels
        logic             inh_lat;     // latched inhibit
        logic             fault;       // fault event held
        logic             list_pls;    // list advance pulse
        logic             log_pls;     // logger start/stop pulse
        logic             trg_pls;     // trigger out pulse
        logic [2:0]       pin_out;     // pin levels
        logic [2:0]       oe_n;        // pin drive enables, low drives
        logic             dis;         // outputs disabled
        logic [31:0]      code;        // security code
        logic             unlocked;    // security state
        logic             keys_lk;     // panel keys locked
        logic [29:0]      hold_cnt;    // key hold counter
        logic [5:0]       cnt;         // log entries
        logic [5:0]       sel;         // selected entry, 1 = newest
    } adpil_st_s;

    adpil_st_s st_ff;
    adpil_st_s nxt_st;
    logic [49:0] log_mem [50];  // {time, chan, code}
    logic [3:0]  sync_in;       // pins and key button, synchronised
    logic [2:0]  asrt;          // asserted logic level per pin
    logic [5:0]  rd_idx;        // array index of selected entry
    logic        wr_take;       // write taken this edge
    logic        log_wr;        // error recorded this edge

    adpil_sync #(.W(4)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_async   ({i_key_lock_btn, i_pin_in}),
        .o_sync    (sync_in)
    );

    // ----------------------------------------------------------------
    // per-pin polarity
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 3; g++) begin : g_pol
        assign asrt[g] = sync_in[g] ^ st_ff.pol_neg[g];
    end

    // newest entry sits at cnt-1, so entry k is at cnt-k
    assign rd_idx  = st_ff.cnt - st_ff.sel;
    assign wr_take = i_write && !st_ff.wait_r;
    assign log_wr  = i_err_valid && (st_ff.cnt < LOG_DEPTH);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic       wr_cfg;
        logic       wr_ctl;
        logic       clr_log;
        logic [2:0] rise;
        logic       trg_any;
        logic       inh_in;
        logic       live;
        wr_cfg  = wr_take && (i_address == ADR_PIN_CFG);
        wr_ctl  = wr_take && (i_address == ADR_CTRL);
        clr_log = wr_take && (i_address == ADR_LOG_CTRL) && i_writedata[LOG_CLR_BIT];
        rise    = asrt & ~st_ff.in_prev;
        trg_any = 1'b0;
        inh_in  = 1'b0;
        live    = 1'b0;
        nxt_st  = st_ff;
        nxt_st.in_prev = asrt;
        // one wait cycle per access, then released for one edge
        nxt_st.wait_r = !((i_read || i_write) && st_ff.wait_r);
        // configuration writes
        if (wr_cfg) begin
            for (int i = 0; i < 3; i++) begin
                nxt_st.fn[i] = adpil_fn_e'(i_writedata[i*FN_W +: FN_W]);
            end
            nxt_st.pol_neg  = i_writedata[POL_LSB +: 3];
            nxt_st.inh_mode = adpil_inh_e'(i_writedata[INH_LSB +: 2]);
        end
        if (wr_take && (i_address == ADR_GPIO)) begin
            nxt_st.gp_out = i_writedata[2:0];
        end
        if (wr_ctl) begin
            nxt_st.ctrl = i_writedata[CT_W-1:0];
        end
        // trigger inputs
        for (int i = 0; i < 3; i++) begin
            if (st_ff.fn[i] == FN_TRG_IN && rise[i]) begin
                trg_any = 1'b1;
            end
        end
        nxt_st.list_pls = trg_any && st_ff.ctrl[CT_LIST_SRC];
        nxt_st.log_pls  = trg_any && st_ff.ctrl[CT_LOG_SRC];
        // trigger out only while the list runs
        nxt_st.trg_pls = i_list_running &&
            (st_ff.ctrl[CT_STEP_END] ? i_step_end : i_step_begin);
        // fault event; a new event beats a clear in the same cycle
        if (wr_ctl && i_writedata[CT_FLT_CLR]) begin
            nxt_st.fault = 1'b0;
        end
        if (i_err_valid && st_ff.ctrl[CT_FAULT_EN] && |(i_err_code & ERR_FAULT)) begin
            nxt_st.fault = 1'b1;
        end
        // inhibit exists only on pin three
        inh_in = (st_ff.fn[2] == FN_FLT_INH) && asrt[2];
        live   = 1'b0;
        unique case (st_ff.inh_mode)
            INH_OFF:   live = 1'b0;
            INH_LATCH: live = 1'b0;
            INH_LIVE:  live = inh_in;
            default:   live = 1'b0;   // unused code
        endcase
        // release only by mode change or re-enable, never by the input
        if ((wr_cfg && i_writedata[INH_LSB +: 2] != st_ff.inh_mode) ||
            (wr_ctl && i_writedata[CT_REENABLE])) begin
            nxt_st.inh_lat = 1'b0;
        end
        if (st_ff.inh_mode == INH_LATCH && inh_in && !st_ff.in_prev[2]) begin
            nxt_st.inh_lat = 1'b1;
        end
        if (st_ff.inh_mode != INH_LATCH && !wr_cfg) begin
            nxt_st.inh_lat = 1'b0;
        end
        nxt_st.dis = st_ff.fault || st_ff.inh_lat || live;
        // pin drivers
        for (int i = 0; i < 3; i++) begin
            nxt_st.oe_n[i]    = 1'b1;
            nxt_st.pin_out[i] = st_ff.pol_neg[i];
            unique case (st_ff.fn[i])
                FN_GP_OUT: begin
                    nxt_st.oe_n[i]    = 1'b0;
                    nxt_st.pin_out[i] = st_ff.gp_out[i] ^ st_ff.pol_neg[i];
                end
                FN_TRG_OUT: begin
                    nxt_st.oe_n[i]    = 1'b0;
                    nxt_st.pin_out[i] = st_ff.trg_pls ^ st_ff.pol_neg[i];
                end
                FN_FLT_INH: begin
                    // pins one and two drive fault; pin three is the inhibit input
                    if (i != 2) begin
                        nxt_st.oe_n[i]    = 1'b0;
                        nxt_st.pin_out[i] = st_ff.fault ^ st_ff.pol_neg[i];
                    end
                end
                FN_NONE, FN_GP_IN, FN_TRG_IN: begin
                    nxt_st.oe_n[i] = 1'b1;
                end
                default: nxt_st.oe_n[i] = 1'b1; // illegal code: stay off the pin
            endcase
        end
        // security gate
        if (wr_take && i_address == ADR_CODE_IN && i_writedata == st_ff.code) begin
            nxt_st.unlocked = 1'b1;
        end
        if (wr_take && i_address == ADR_CODE_NEW && st_ff.unlocked) begin
            nxt_st.code = i_writedata;
        end
        if (wr_take && i_address == ADR_LOCK) begin
            nxt_st.unlocked = 1'b0;
        end
        // key lock: holding the key for the full time locks the panel
        if (st_ff.ctrl[CT_KEY_OPT] && sync_in[3] && !st_ff.keys_lk) begin
            nxt_st.hold_cnt = st_ff.hold_cnt + 30'h1;
        end else begin
            nxt_st.hold_cnt = 30'h0;
        end
        if (wr_ctl && i_writedata[CT_UNLOCK]) begin
            nxt_st.keys_lk = 1'b0;
        end
        if (st_ff.ctrl[CT_KEY_OPT] && st_ff.hold_cnt >= P_KEY_HOLD_CYC - 30'h1) begin
            nxt_st.keys_lk = 1'b1;
        end
        // error log; a clear with a coincident error keeps the new error, except when the log was full, where it is dropped
        if (wr_take && i_address == ADR_LOG_CTRL) begin
            nxt_st.sel = i_writedata[5:0];
        end
        if (clr_log) begin
            nxt_st.cnt = 6'h0;
        end
        if (log_wr) begin
            nxt_st.cnt = clr_log ? 6'h1 : st_ff.cnt + 6'h1;
        end
        // read data, captured during the wait cycle
        nxt_st.rdata = 32'h0;
        unique case (i_address)
            ADR_PIN_CFG: nxt_st.rdata = {18'h0, st_ff.inh_mode, st_ff.pol_neg,
                                         st_ff.fn[2], st_ff.fn[1], st_ff.fn[0]};
            ADR_GPIO:    nxt_st.rdata = {25'h0, asrt, 1'b0, st_ff.gp_out};
            ADR_CTRL:    nxt_st.rdata = {27'h0, st_ff.ctrl};
            ADR_STATUS:  nxt_st.rdata = {18'h0, st_ff.cnt, 3'h0, st_ff.keys_lk,
                                         st_ff.unlocked, st_ff.fault, st_ff.inh_lat,
                                         st_ff.dis};
            ADR_LOG_CTRL: nxt_st.rdata = {26'h0, st_ff.sel};
            ADR_LOG_DATA: nxt_st.rdata = (st_ff.sel != 6'h0 && st_ff.sel <= st_ff.cnt) ?
                                         {14'h0, log_mem[rd_idx][17:0]} : 32'h0;
            ADR_LOG_TIME: nxt_st.rdata = (st_ff.sel != 6'h0 && st_ff.sel <= st_ff.cnt) ?
                                         log_mem[rd_idx][49:18] : 32'h0;
            default:     nxt_st.rdata = 32'h0; // code and lock read as zero
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            // pins released and no function until software picks one
            st_ff <= '{wait_r: 1'b1, code: CODE_RST, oe_n: 3'h7, inh_mode: INH_OFF,
                       fn: '{FN_NONE, FN_NONE, FN_NONE}, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // log storage; cleared entries need no reset since count gates them
    always_ff @(posedge i_ref_clk) begin
        if (log_wr) begin
            log_mem[(wr_take && i_address == ADR_LOG_CTRL && i_writedata[LOG_CLR_BIT]) ?
                    6'h0 : st_ff.cnt] <= {i_timestamp, i_err_chan, i_err_code};
        end
    end

    assign o_readdata        = st_ff.rdata;
    assign o_waitrequest     = st_ff.wait_r;
    assign o_pin_out         = st_ff.pin_out;
    assign o_pin_oe_n        = st_ff.oe_n;
    assign o_list_step_trig  = st_ff.list_pls;
    assign o_log_toggle      = st_ff.log_pls;
    assign o_out_disable     = st_ff.dis;
    assign o_keys_locked     = st_ff.keys_lk;
    assign o_secure_unlocked = st_ff.unlocked;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    sequence s_trg_rise(int k);
        st_ff.fn[k] == FN_TRG_IN && asrt[k] && !st_ff.in_prev[k];
    endsequence

    AST_RESET_NONE: assert property ($fell(i_reset) |-> o_pin_oe_n == 3'h7 && !o_out_disable)
        else $error("pins driven after reset");
    AST_DEFAULTS: assert property ($fell(i_reset) |-> st_ff.fn == '0 && st_ff.pol_neg == 3'h0
        && st_ff.inh_mode == INH_OFF && !st_ff.ctrl[CT_KEY_OPT])
        else $error("defaults wrong after reset");
    AST_GP_OUT: assert property (st_ff.fn[0] == FN_GP_OUT |=>
        !o_pin_oe_n[0] && o_pin_out[0] == ($past(st_ff.gp_out[0]) ^ $past(st_ff.pol_neg[0])))
        else $error("general output level wrong");
    AST_LIST_ADV: assert property (s_trg_rise(0) ##0 st_ff.ctrl[CT_LIST_SRC]
        |=> o_list_step_trig)
        else $error("list advance missing");
    AST_LOG_TRG: assert property (s_trg_rise(1) ##0 st_ff.ctrl[CT_LOG_SRC] |=> o_log_toggle)
        else $error("logger trigger missing");
    AST_TRG_IDLE: assert property (!i_list_running |=> !st_ff.trg_pls)
        else $error("trigger out while list idle");
    AST_FAULT: assert property (i_err_valid && st_ff.ctrl[CT_FAULT_EN] && i_err_code[0]
        |=> ##1 o_out_disable)
        else $error("fault did not disable outputs");
    AST_INH_OFF: assert property (st_ff.inh_mode == INH_OFF && !st_ff.fault && !st_ff.inh_lat
        |=> !o_out_disable)
        else $error("inhibit off still disables");
    AST_LATCH_HOLD: assert property (st_ff.inh_lat && !wr_take |=> st_ff.inh_lat)
        else $error("latched inhibit dropped without action");
    AST_LIVE: assert property (st_ff.inh_mode == INH_LIVE && st_ff.fn[2] == FN_FLT_INH
        && !st_ff.fault |=> o_out_disable == $past(asrt[2]))
        else $error("live inhibit not followed");
    AST_LOG_FULL: assert property (st_ff.cnt == LOG_DEPTH && !wr_take |=> st_ff.cnt == LOG_DEPTH)
        else $error("full log changed");
    AST_RELOCK: assert property (wr_take && i_address == ADR_LOCK |=> !o_secure_unlocked)
        else $error("lock command ignored");

    sequence s_begin_step;
        i_list_running && i_step_begin && !st_ff.ctrl[CT_STEP_END];
    endsequence

    AST_TRG_OUT: assert property (s_begin_step ##1 st_ff.fn[2] == FN_TRG_OUT
        && !st_ff.pol_neg[2] |=> o_pin_out[2])
        else $error("trigger out pulse missing");
    AST_FAULT_PIN: assert property (st_ff.fault && st_ff.fn[0] == FN_FLT_INH
        && !st_ff.pol_neg[0] |=> o_pin_out[0] && !o_pin_oe_n[0])
        else $error("fault pin not driven");
endmodule

// ---- tb/adpil_ext_model.sv ----
// external equipment on the three port pins
// assumes the bench sets the levels it applies when the device lets go
`timescale 1ns/10ps
module adpil_ext_model (
    input  wire logic [2:0] i_pin_out,
    input  wire logic [2:0] i_pin_oe_n,
    input  wire logic [2:0] i_ext_lvl,
    output logic      [2:0] o_wire
);
    // ------------------------------------------------------------
    // wire level: device wins while it drives, else our own level
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            o_wire[i] = !i_pin_oe_n[i] ? i_pin_out[i] : i_ext_lvl[i];
        end
    end
endmodule

// ---- tb/adpil_top_tb_top.sv ----
// self-checking bench for the digital port block
// assumes one 200 MHz clock and an Avalon-MM master built here
`timescale 1ns/10ps
module adpil_top_tb_top;
    import adpil_pkg::*;
    logic        clk = 0, rst = 1, rd = 0, wr = 0, ev = 0, btn = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, ts = 32'h0, seed = 32'h4B;
    logic [15:0] ec = 16'h0;
    logic [1:0]  ch = 2'h0;
    logic [2:0]  pin, pout, poe_n, ext = 3'h0;
    logic        wt, dis, keys, tl, tg, unl;
    logic        lr = 0, sb = 0, se = 0; // list running, step begin, step end
    int          n_tl = 0, n_tg = 0, n_to = 0; // pulse cycles seen
    logic [31:0] nc; // replacement security code
    logic [63:0] exq[$]; // {mask, expected} per read
    int          err_count = 0, num_checks = 0;
    logic [17:0] last; // last recorded {chan, code}
    always #2.5 clk = ~clk;
    adpil_ext_model u_adpil_ext_model (.i_pin_out(pout), .i_pin_oe_n(poe_n),
        .i_ext_lvl(ext), .o_wire(pin));
    adpil_top #(.P_KEY_HOLD_CYC(30'd20)) u_adpil_top (.i_ref_clk(clk), .i_reset(rst),
        .i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd), .o_readdata(rdat),
        .o_waitrequest(wt), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe_n(poe_n),
        .i_list_running(lr), .i_step_begin(sb), .i_step_end(se),
        .o_list_step_trig(tl), .o_log_toggle(tg), .o_out_disable(dis), .i_err_valid(ev),
        .i_err_code(ec), .i_err_chan(ch), .i_timestamp(ts), .i_key_lock_btn(btn),
        .o_keys_locked(keys), .o_secure_unlocked(unl));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // one bus cycle; held until waitrequest is seen low at an edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        adr <= a;
        rd <= !w;
        wr <= w;
        wd <= w ? d : 32'h0;
        if (!w) exq.push_back({m, d});
        do @(posedge clk); while (wt !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk); // a free edge before the next request
    endtask
    // one error pulse with the given code, a random channel and stamp
    task automatic err(input logic [15:0] c);
        ev <= 1'b1;
        ec <= c;
        ch <= 2'(xs() % 3);
        ts <= xs();
        @(posedge clk);
        ev <= 1'b0;
        @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // read monitor: oldest note is compared at each taken read
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rd && wt === 1'b0 && exq.size() > 0) begin
            chk("readdata", exq[0][31:0], rdat & exq[0][63:32]);
            void'(exq.pop_front());
        end
        if (!rst) begin
            n_tl <= n_tl + int'(tl);
            n_tg <= n_tg + int'(tg);
            n_to <= n_to + int'(pin[2] & !poe_n[2]);
        end
    end
    task automatic complete_run();
        if (err_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog: the whole sequence needs well under 4000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        complete_run();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(0, ADR_PIN_CFG, 32'h0, 32'h3FFF);
        acc(0, ADR_CTRL, 32'h0, 32'h1F);
        acc(0, ADR_STATUS, 32'h0, 32'h1F);
        // general out on pin 1, negative general in on pin 2
        acc(1, ADR_PIN_CFG, 32'h40A, 0);
        acc(1, ADR_GPIO, 32'h1, 0);
        repeat (6) @(posedge clk);
        chk("pin1", 2'b10, {pin[0], poe_n[0]});
        acc(0, ADR_GPIO, 32'h20, 32'h20);
        // live then latched inhibit on pin 3
        acc(1, ADR_PIN_CFG, 32'h2140, 0);
        ext <= 3'b100;
        repeat (8) @(posedge clk);
        chk("live_on", 1, dis);
        ext <= 3'b000;
        repeat (8) @(posedge clk);
        chk("live_off", 0, dis);
        acc(1, ADR_PIN_CFG, 32'h1140, 0);
        ext <= 3'b100;
        repeat (8) @(posedge clk);
        ext <= 3'b000;
        repeat (8) @(posedge clk);
        chk("latched", 1, dis);
        acc(1, ADR_CTRL, 32'h20, 0);
        repeat (3) @(posedge clk);
        chk("reenable", 0, dis);
        acc(1, ADR_PIN_CFG, 32'h0140, 0);
        ext <= 3'b100;
        repeat (8) @(posedge clk);
        chk("inh_off", 0, dis);
        // fill the log past its depth
        for (int i = 0; i < 51; i++) begin
            err(16'h1 << (xs() % 4));
            if (i < 50) last = {ch, ec};
        end
        acc(0, ADR_STATUS, 32'h3200, 32'h3F00);
        acc(1, ADR_LOG_CTRL, 32'h1, 0);
        acc(0, ADR_LOG_DATA, {14'h0, last}, 32'h3FFFF);
        acc(1, ADR_LOG_CTRL, 32'h100, 0);
        acc(0, ADR_STATUS, 32'h0, 32'h3F00);
        // fault event forces setpoints down and drives the fault pin 1
        acc(1, ADR_PIN_CFG, 32'h5, 0);
        acc(1, ADR_CTRL, 32'h1, 0);
        err(ERR_OVP);
        repeat (3) @(posedge clk);
        chk("fault_dis", 1, dis);
        chk("fault_pin", 2'b10, {pin[0], poe_n[0]});
        acc(0, ADR_STATUS, 32'h104, 32'h3F04);
        acc(1, ADR_CTRL, 32'h80, 0);
        repeat (3) @(posedge clk);
        chk("fault_clr", 0, dis);
        chk("fault_pin_clr", 0, pin[0]);
        // security code gate
        acc(1, ADR_CODE_IN, 32'h12345678, 0);
        acc(0, ADR_STATUS, 32'h0, 32'h8);
        acc(1, ADR_CODE_IN, CODE_RST, 0);
        acc(0, ADR_STATUS, 32'h8, 32'h8);
        nc = xs();
        acc(1, ADR_CODE_NEW, nc, 0);
        acc(1, ADR_LOCK, 32'h0, 0);
        chk("unlocked", 0, unl);
        acc(1, ADR_CODE_NEW, ~nc, 0);
        acc(1, ADR_CODE_IN, CODE_RST, 0);
        chk("old_code", 0, unl);
        acc(1, ADR_CODE_IN, nc, 0);
        chk("new_code", 1, unl);
        // key lock: ignored with option off, then held long enough
        btn <= 1'b1;
        repeat (40) @(posedge clk);
        chk("keys_opt_off", 0, keys);
        btn <= 1'b0;
        acc(1, ADR_CTRL, 32'h10, 0);
        btn <= 1'b1;
        repeat (40) @(posedge clk);
        btn <= 1'b0;
        chk("keys_lock", 1, keys);
        acc(1, ADR_CTRL, 32'h50, 0);
        repeat (3) @(posedge clk);
        chk("keys_unlock", 0, keys);
        // trigger inputs on pins 1 and 2, trigger out on pin 3
        acc(1, ADR_PIN_CFG, 32'h11B, 0);
        for (int k = 0; k < 2; k++) begin
            acc(1, ADR_CTRL, 32'h4 << k, 0);
            ext <= 3'b001 << k;
            repeat (6) @(posedge clk);
            ext <= 3'b000;
            repeat (4) @(posedge clk);
        end
        chk("list_trig", 1, n_tl);
        chk("log_trig", 1, n_tg);
        // step begin while idle, step end in begin mode, then a real begin
        sb <= 1'b1;
        @(posedge clk);
        sb <= 1'b0;
        lr <= 1'b1;
        se <= 1'b1;
        @(posedge clk);
        se <= 1'b0;
        sb <= 1'b1;
        @(posedge clk);
        sb <= 1'b0;
        repeat (4) @(posedge clk);
        chk("trig_out", 1, n_to);
        lr <= 1'b0;
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule
